// ==== pdc_pkg.sv ====
// package: constants shared by the pwm output disable control ends
package pdc_pkg;
	// clock and latency figures
	localparam int CLK_MHZ         = 50;
	localparam int SHORT_MAX_CYC   = 4;
	localparam int SWDIS_MAX_CYC   = 3;
	localparam int CMP_MAX_CYC     = 7;
	localparam int OSC_OFF_US      = 10;
	localparam int OSC_OFF_CYC     = OSC_OFF_US * CLK_MHZ;
	localparam int OSC_FLAG_MS     = 1;
	localparam int OSC_FLAG_CYC    = OSC_FLAG_MS * 1000 * CLK_MHZ;
	// oscillator watchdog: cycles without a toggle before a stop is declared
	localparam logic [7:0] OSC_TIMEOUT = 8'h40;

	// register offsets (byte addresses)
	localparam logic [7:0] OFF_CTRL   = 8'h00;
	localparam logic [7:0] OFF_STATUS = 8'h04;
	localparam logic [7:0] OFF_MASK   = 8'h08;
	localparam logic [7:0] OFF_MON    = 8'h0C;

	// status and mask bit positions
	localparam int BIT_SHORT   = 0;
	localparam int BIT_CMP     = 1;
	localparam int BIT_CLKGEN  = 2;
	localparam int BIT_OSC     = 3;
	localparam int NUM_FLAGS   = 4;
	// control bit position
	localparam int BIT_SWDIS   = 0;

	// reset values
	localparam logic [3:0] MASK_RST   = 4'hF;
	localparam logic [3:0] STATUS_RST = 4'h0;
endpackage

// ==== pdc_if.sv ====
// interface: link between the pwm timer side and the disable controller
`timescale 1ns/1ps
interface pdc_if;
	logic [5:0] pwm_out;     // timer drive: {3inv,3,2inv,2,1inv,1}
	logic [5:0] pwm_pin;     // pin level seen (drive or released)
	logic       pwm_hiz;     // outputs forced to high impedance
	logic       cmp_out;     // comparator output, non inverted
	logic       osc_clk_tog; // main oscillator activity toggle

	modport device (input pwm_out, input cmp_out, input osc_clk_tog,
		output pwm_pin, output pwm_hiz);
	modport timer (output pwm_out, output cmp_out, output osc_clk_tog,
		input pwm_pin, input pwm_hiz);
endinterface

// ==== pdc_timer_end.sv ====
// module: pwm timer end that drives six phases and reports sensors
`timescale 1ns/1ps
module pdc_timer_end
	import pdc_pkg::*;
(
	// clock and reset
	input  wire logic pclk,
	input  wire logic presetn,
	// user side
	input  wire logic [5:0] phase_drv,
	input  wire logic       cmp_level,
	input  wire logic       osc_running,
	output logic            out_disabled,
	// link
	pdc_if.timer            lnk
);
	logic tog_q;

	// oscillator activity toggles only while the crystal runs
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tog_q <= 1'b0;
		end else if (osc_running) begin
			tog_q <= ~tog_q;
		end
	end

	// drive pattern and sensors straight onto the link
	assign lnk.pwm_out     = phase_drv;
	assign lnk.cmp_out     = cmp_level;
	assign lnk.osc_clk_tog = tog_q;
	assign out_disabled    = lnk.pwm_hiz;
endmodule

// ==== pdc_device.sv ====
// module: pwm output disable controller with apb register file
`timescale 1ns/1ps
module pdc_device
	import pdc_pkg::*;
(
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// events
	output logic             irq,
	output logic             nmi,
	// link
	pdc_if.device            lnk
);
	import pdc_pkg::*;

	// ********************************
	// state
	// ********************************
	logic [3:0] status_q;
	logic [3:0] mask_q;
	logic       swdis_q;
	logic       short_q;
	logic       cmp_q;
	logic       cmp_prev_q;
	logic       tog_q;
	logic [7:0] osc_cnt_q;
	logic       osc_stop_q;
	logic       hiz_q;
	logic [3:0] set_ev;
	logic       wr_en;
	logic       rd_en;
	logic       short_now;

	assign wr_en = psel && penable && pwrite;
	assign rd_en = psel && penable && !pwrite;

	// ********************************
	// detection
	// ********************************
	// pair short: both sides low in the same cycle
	assign short_now = (~lnk.pwm_out[0] & ~lnk.pwm_out[1]) |
		(~lnk.pwm_out[2] & ~lnk.pwm_out[3]) |
		(~lnk.pwm_out[4] & ~lnk.pwm_out[5]);

	// register the pair short result and the comparator level
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			short_q    <= 1'b0;
			cmp_q      <= 1'b0;
			cmp_prev_q <= 1'b0;
		end else begin
			short_q    <= short_now;
			cmp_q      <= lnk.cmp_out;
			cmp_prev_q <= cmp_q;
		end
	end

	// oscillator watchdog: no toggle for a while means stopped;
	// timeout far below the ten microsecond bound
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tog_q      <= 1'b0;
			osc_cnt_q  <= 8'h00;
			osc_stop_q <= 1'b0;
		end else begin
			tog_q <= lnk.osc_clk_tog;
			if (tog_q != lnk.osc_clk_tog) begin
				osc_cnt_q  <= 8'h00;
				osc_stop_q <= 1'b0;
			end else if (osc_cnt_q == OSC_TIMEOUT) begin
				osc_stop_q <= 1'b1;
			end else begin
				osc_cnt_q <= osc_cnt_q + 8'h01;
			end
		end
	end

	// ********************************
	// sticky flags
	// ********************************
	always_comb begin
		set_ev              = 4'h0;
		set_ev[BIT_SHORT]   = short_q;
		set_ev[BIT_CMP]     = cmp_q & ~cmp_prev_q;
		set_ev[BIT_CLKGEN]  = osc_stop_q & hiz_q;
		set_ev[BIT_OSC]     = osc_stop_q & hiz_q;
	end

	// set wins over write-one-to-clear; flags persist until cleared
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status_q <= STATUS_RST;
		end else if (wr_en && paddr == OFF_STATUS) begin
			status_q <= (status_q & ~pwdata[3:0]) | set_ev;
		end else begin
			status_q <= status_q | set_ev;
		end
	end

	// control and mask registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			swdis_q <= 1'b0;
			mask_q  <= MASK_RST;
		end else if (wr_en) begin
			if (paddr == OFF_CTRL) begin
				swdis_q <= pwdata[BIT_SWDIS];
			end
			if (paddr == OFF_MASK) begin
				mask_q <= pwdata[3:0];
			end
		end
	end

	// ********************************
	// output gating
	// ********************************
	// one register stage keeps every source inside its latency bound;
	// the oscillator stop gates directly so flags follow the pin change
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hiz_q <= 1'b0;
		end else begin
			hiz_q <= swdis_q | (|status_q) | set_ev[BIT_SHORT] |
				set_ev[BIT_CMP] | osc_stop_q;
		end
	end

	assign lnk.pwm_hiz = hiz_q;
	assign lnk.pwm_pin = hiz_q ? 6'h3F : lnk.pwm_out; // released pins idle high

	// ********************************
	// interrupts
	// ********************************
	// mask bit 1 enables; level held while flag set
	assign irq = |(status_q[BIT_CMP:BIT_SHORT] & mask_q[BIT_CMP:BIT_SHORT]);
	assign nmi = status_q[BIT_OSC];

	// ********************************
	// apb read
	// ********************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (psel && !penable && !pwrite) begin
			unique case (paddr)
				OFF_CTRL:   prdata <= {31'h0, swdis_q};
				OFF_STATUS: prdata <= {28'h0, status_q};
				OFF_MASK:   prdata <= {28'h0, mask_q};
				OFF_MON:    prdata <= {30'h0, hiz_q, cmp_q};
				default:    prdata <= 32'h0000_0000;
			endcase
		end
	end

	assign pready  = 1'b1;
	assign pslverr = (rd_en || wr_en) && paddr != OFF_CTRL &&
		paddr != OFF_STATUS && paddr != OFF_MASK && paddr != OFF_MON;
endmodule

// ==== pdc_assertions.sv ====
// checker: link-level properties of the pwm output disable control
`timescale 1ns/1ps
module pdc_assertions
	import pdc_pkg::*;
(
	// clock and reset
	input wire logic       pclk,
	input wire logic       presetn,
	// link
	input wire logic [5:0] pwm_out,
	input wire logic [5:0] pwm_pin,
	input wire logic       pwm_hiz,
	input wire logic       cmp_out,
	input wire logic       osc_clk_tog
);
	logic       sh;
	logic       tog_q;
	logic [7:0] idle_q;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// any pair with both sides at the active low level
	assign sh = pwm_out[1:0] == 2'h0 || pwm_out[3:2] == 2'h0 ||
		pwm_out[5:4] == 2'h0;
	// idle count saturates so a long stop stays visible
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tog_q  <= 1'b0;
			idle_q <= 8'h00;
		end else begin
			tog_q  <= osc_clk_tog;
			if (osc_clk_tog != tog_q)
				idle_q <= 8'h00;
			else if (idle_q != 8'hFF)
				idle_q <= idle_q + 8'h01;
		end
	end
	sequence s_sh2; sh ##1 sh; endsequence
	property p_sh; sh |-> ##[1:4] pwm_hiz; endproperty
	a_sh: assert property (p_sh) else $error("short not cut");
	property p_keep; s_sh2 |=> pwm_hiz; endproperty
	a_keep: assert property (p_keep) else $error("short hiz dropped");
	property p_pin; pwm_hiz |-> pwm_pin == 6'h3F; endproperty
	a_pin: assert property (p_pin) else $error("pins driven in hiz");
	property p_pass; !pwm_hiz |-> pwm_pin == pwm_out; endproperty
	a_pass: assert property (p_pass) else $error("pins not passed");
	property p_cmp; $rose(cmp_out) |-> ##[1:7] pwm_hiz; endproperty
	a_cmp: assert property (p_cmp) else $error("cmp not cut");
	property p_cmpin; $rose(cmp_out) |-> ##[1:7] pwm_pin == 6'h3F; endproperty
	a_cmpin: assert property (p_cmpin) else $error("cmp pins on");
	property p_osc; idle_q == OSC_TIMEOUT |-> ##[1:8] pwm_hiz; endproperty
	a_osc: assert property (p_osc) else $error("osc stop slow");
	// from two cycles past the timeout the stop must hold the pins in hiz
	property p_oscst; idle_q >= OSC_TIMEOUT + 8'h02 |-> pwm_hiz; endproperty
	a_oscst: assert property (p_oscst) else $error("osc stop no hiz");
endmodule

// ==== pwm_output_disable_control_tb_top.sv ====
// testbench: both ends joined, apb orders and link events
`timescale 1ns/1ps
module pwm_output_disable_control_tb_top;
	import pdc_pkg::*;
	logic        pclk = 1'b0, presetn = 1'b0;
	logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rdat;
	logic        pready, pslverr, irq, nmi, out_disabled, err;
	logic [5:0]  phase_drv = 6'h15;
	logic        cmp_level = 1'b0, osc_running = 1'b1;
	int          miscompares = 0, total_checks = 0, cyc = 0;
	pdc_if u_pdc_if ();
	pdc_device u_pdc_device (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
		.nmi(nmi), .lnk(u_pdc_if.device));
	pdc_timer_end u_pdc_timer_end (.pclk(pclk), .presetn(presetn),
		.phase_drv(phase_drv), .cmp_level(cmp_level),
		.osc_running(osc_running), .out_disabled(out_disabled),
		.lnk(u_pdc_if.timer));
	pdc_assertions u_pdc_assertions (.pclk(pclk), .presetn(presetn),
		.pwm_out(u_pdc_if.pwm_out), .pwm_pin(u_pdc_if.pwm_pin),
		.pwm_hiz(u_pdc_if.pwm_hiz), .cmp_out(u_pdc_if.cmp_out),
		.osc_clk_tog(u_pdc_if.osc_clk_tog));
	// ****
	// shared tasks
	// ****
	always #10 pclk = ~pclk;
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		total_checks++;
		if (s !== e) begin
			miscompares++;
			$display("[FAIL] %0t seen %h exp %h", $time, s, e);
		end
	endtask
	// one apb transfer; waits on pready, data taken at that edge
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge pclk);
		psel    <= 1'b1;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rdat = prdata;
		err  = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(rdat, e);
	endtask
	// sample off the edge so updates have landed
	task automatic wt(input int n);
		repeat (n) @(posedge pclk);
		#1;
	endtask
	// ****
	// scenarios
	// ****
	task automatic t_regs();
		rdc(OFF_STATUS, 32'h0);
		rdc(OFF_MASK, 32'hF);
		apb(1'b1, 8'h10, 32'h1);
		chk(32'(err), 32'h1);
		wt(3);
		chk(32'(out_disabled), 32'h0);
	endtask
	// one cycle of a shorted pair, then latched until cleared
	task automatic t_short();
		@(posedge pclk);
		phase_drv <= 6'h14;
		@(posedge pclk);
		phase_drv <= 6'h15;
		wt(3);
		chk(32'(out_disabled), 32'h1);
		chk(32'(u_pdc_if.pwm_pin), 32'h3F);
		rdc(OFF_STATUS, 32'h1);
		chk(32'(irq), 32'h1);
		apb(1'b1, OFF_MASK, 32'hE);
		wt(0);
		chk(32'(irq), 32'h0);
		apb(1'b1, OFF_STATUS, 32'h1);
		wt(3);
		chk(32'(u_pdc_if.pwm_pin), 32'h15);
		apb(1'b1, OFF_MASK, 32'hF);
		// two cycles across pairs two and three, latched as one event
		@(posedge pclk);
		phase_drv <= 6'h11;
		@(posedge pclk);
		phase_drv <= 6'h05;
		@(posedge pclk);
		phase_drv <= 6'h15;
		wt(3);
		chk(32'(out_disabled), 32'h1);
		rdc(OFF_STATUS, 32'h1);
		apb(1'b1, OFF_STATUS, 32'h1);
		wt(3);
		chk(32'(out_disabled), 32'h0);
	endtask
	task automatic t_sw();
		apb(1'b1, OFF_CTRL, 32'h1);
		wt(2);
		chk(32'(out_disabled), 32'h1);
		apb(1'b1, OFF_CTRL, 32'h0);
		wt(3);
		chk(32'(out_disabled), 32'h0);
	endtask
	// comparator held high across the clear must not re-trigger
	task automatic t_cmp();
		@(posedge pclk);
		cmp_level <= 1'b1;
		wt(CMP_MAX_CYC + 1);
		chk(32'(out_disabled), 32'h1);
		rdc(OFF_STATUS, 32'h2);
		apb(1'b1, OFF_CTRL, 32'h1);
		apb(1'b1, OFF_STATUS, 32'h2);
		wt(4);
		rdc(OFF_STATUS, 32'h0);
		cmp_level <= 1'b0;
		wt(4);
		rdc(OFF_MON, 32'h2);
		apb(1'b1, OFF_CTRL, 32'h0);
		wt(3);
		chk(32'(out_disabled), 32'h0);
	endtask
	task automatic t_osc();
		@(posedge pclk);
		osc_running <= 1'b0;
		wt(OSC_TIMEOUT + 8);
		chk(32'(out_disabled), 32'h1);
		chk(32'(nmi), 32'h1);
		rdc(OFF_STATUS, 32'hC);
		osc_running <= 1'b1;
		wt(4);
		apb(1'b1, OFF_STATUS, 32'h4);
		apb(1'b1, OFF_STATUS, 32'h8);
		wt(3);
		chk(32'(nmi), 32'h0);
		chk(32'(out_disabled), 32'h0);
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// ****
	// sequence and hang limit
	// ****
	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		t_regs();
		t_short();
		t_sw();
		t_cmp();
		t_osc();
		final_report();
	end
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 3000) begin
			miscompares++;
			final_report();
		end
	end
endmodule
